// ===== hw/spp_pkg.sv
// shared constants, types and decoders of the serial PROM programming port
package spp_pkg;

   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_READ = 8'h15;   // read one word
   localparam logic [7:0] CMD_PROG = 8'h25;   // program one word
   localparam logic [7:0] CMD_VERIFY = 8'h35; // program, then read back

   // ----------------------------------------------------------------
   // framing
   // ----------------------------------------------------------------
   localparam logic [2:0] BIT_LAST = 3'h7;    // last bit of a transfer
   localparam logic [4:0] OUT_BITS = 5'h10;   // bits in one output word
   localparam logic [4:0] OUT_NONE = 5'h00;   // no output bit sent yet
   localparam logic [4:0] OUT_FIRST = 5'h01;  // first output bit sent

   // transfer index within one operation
   localparam logic [2:0] IDX_CMD = 3'h0;     // command code
   localparam logic [2:0] IDX_AL = 3'h1;      // address low
   localparam logic [2:0] IDX_AH = 3'h2;      // address high
   localparam logic [2:0] IDX_DL = 3'h3;      // data low (in or out)
   localparam logic [2:0] IDX_DH = 3'h4;      // data high (in or out)
   localparam logic [2:0] IDX_VL = 3'h5;      // verify data low
   localparam logic [2:0] IDX_VH = 3'h6;      // verify data high

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_NONE = 2'h0,
      OP_READ = 2'h1,
      OP_PROG = 2'h2,
      OP_VERIFY = 2'h3
   } spp_op_e;

   typedef enum logic [3:0] {
      ST_CMD = 4'h0,
      ST_AL = 4'h1,
      ST_AH = 4'h2,
      ST_DL = 4'h3,
      ST_DH = 4'h4,
      ST_WLO = 4'h5,
      ST_WHI = 4'h6,
      ST_W2LO = 4'h7,
      ST_W2HI = 4'h8
   } spp_state_e;

   // ----------------------------------------------------------------
   // decoders; opOf is used in both clock domains, the others on the link side only
   // ----------------------------------------------------------------
   function automatic spp_op_e opOf(input logic [7:0] code);
      case (code)
         CMD_READ: opOf = OP_READ;
         CMD_PROG: opOf = OP_PROG;
         CMD_VERIFY: opOf = OP_VERIFY;
         default: opOf = OP_NONE;
      endcase
   endfunction

   // index of the last transfer of an operation
   function automatic logic [2:0] lastIdx(input spp_op_e op);
      case (op)
         OP_READ, OP_PROG: lastIdx = IDX_DH;
         OP_VERIFY: lastIdx = IDX_VH;
         default: lastIdx = IDX_CMD;
      endcase
   endfunction

   // true where a transfer is driven by the device
   function automatic logic isOut(input spp_op_e op,
                                  input logic [2:0] idx);
      isOut = ((op == OP_READ) && (idx >= IDX_DL)) ||
              ((op == OP_VERIFY) && (idx >= IDX_VL));
   endfunction

endpackage

// ===== hw/spp_prog_port.sv
// serial programming port of the one-time-programmable program memory
//
// Functional notes
// - data line sampled on serial clock rise
// - output data changes on serial clock fall
// - transfers are 8 bits, command first
// - read: 15h, address, strobe low fetches
// - read result shifted out low byte first
// - drive from first fall, release after bit 16
// - program: 25h, address, data, strobe writes
// - verify: 35h, address, data, strobe writes
// - second strobe low reads back into latch
// - verify outputs two bytes, seven transfers
// - every transfer shifted least significant bit first
`timescale 1ns/1ps

module spp_prog_port (
   // system clock and reset
   input wire logic clock,
   input wire logic rst,
   // programmer pins
   input wire logic serialClock,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic programStrobeN,
   input wire logic otpProgrammingMode,
   // memory array port
   output logic memRead,
   output logic memWrite,
   output logic [15:0] memAddr,
   output logic [15:0] memWdata,
   input wire logic [15:0] memRdata
);

   // ----------------------------------------------------------------
   // link side: serial clock domain
   // ----------------------------------------------------------------
   logic [7:0] shiftIn;            // incoming bits, lsb enters first
   logic [7:0] nextByte;           // byte as it stands after this bit
   logic [2:0] bitCnt;             // bit position in the transfer
   logic [2:0] byteIdx;            // transfer index in the operation
   spp_pkg::spp_op_e cmdOp;        // operation seen by the link side
   logic [7:0] byteBuf;            // last input byte, held for sys
   logic byteTgl;                  // flips once per input byte
   logic outPhase;                 // current transfer is an output
   logic tailSeen;                 // closing fall of last input seen
   logic [4:0] outCnt;             // output bits already driven
   logic [14:0] outShift;          // output bits still to go

   // ----------------------------------------------------------------
   // system side
   // ----------------------------------------------------------------
   logic [2:0] syncA;              // first stage, read by syncB only
   logic [2:0] syncB;              // second stage
   logic [2:0] syncC;              // third stage
   logic [2:0] stable;             // filtered levels
   logic [2:0] agree;              // second and third stage agree
   logic [2:0] evt;                // filtered level changed
   logic byteEv;                   // new input byte arrived
   logic strobeFall;               // strobe went low
   logic strobeRise;               // strobe went high
   logic modeOn;                   // programming mode active
   spp_pkg::spp_state_e state;     // operation sequencer
   spp_pkg::spp_op_e op;           // operation being run
   logic rdPend;                   // memory read data due this cycle
   logic [15:0] dataLatch;         // fetched word, shifted out later

   assign nextByte = {sdaIn, shiftIn[7:1]};
   assign outPhase = spp_pkg::isOut(cmdOp, byteIdx);

   // ----------------------------------------------------------------
   // input shifter and transfer counter on the rising edge
   // ----------------------------------------------------------------
   // the pin is sampled by its own clock, so no synchroniser here
   always_ff @(posedge serialClock or posedge rst) begin
      if (rst) begin
         shiftIn <= 8'h00;
         bitCnt <= 3'h0;
      end else if (outPhase && (outCnt == spp_pkg::OUT_NONE)) begin
         // turn-round pulse before the first output fall: no data bit,
         // counting it would end the word one bit early
         bitCnt <= bitCnt;
      end else begin
         shiftIn <= nextByte;
         bitCnt <= bitCnt + 3'h1;
      end
   end

   // transfer sequencing; framing is kept only by counting bits,
   // so a lost clock pulse shifts every later byte until reset
   always_ff @(posedge serialClock or posedge rst) begin
      if (rst) begin
         byteIdx <= spp_pkg::IDX_CMD;
         cmdOp <= spp_pkg::OP_NONE;
      end else if (bitCnt == spp_pkg::BIT_LAST) begin
         if (byteIdx == spp_pkg::IDX_CMD) begin
            // unknown codes leave the index at the command slot
            cmdOp <= spp_pkg::opOf(nextByte);
            if (spp_pkg::opOf(nextByte) != spp_pkg::OP_NONE) begin
               byteIdx <= spp_pkg::IDX_AL;
            end
         end else if (byteIdx == spp_pkg::lastIdx(cmdOp)) begin
            byteIdx <= spp_pkg::IDX_CMD;
         end else begin
            byteIdx <= byteIdx + 3'h1;
         end
      end
   end

   // hand each input byte to the system side with a toggle; the
   // buffer then stands for a whole transfer, 512 ns, only a little
   // longer than the at most four system cycles the synchroniser needs
   always_ff @(posedge serialClock or posedge rst) begin
      if (rst) begin
         byteBuf <= 8'h00;
         byteTgl <= 1'b0;
      end else if ((bitCnt == spp_pkg::BIT_LAST) && !outPhase) begin
         byteBuf <= nextByte;
         byteTgl <= ~byteTgl;
      end
   end

   // ----------------------------------------------------------------
   // output driver on the falling edge
   // ----------------------------------------------------------------
   // the fall that closes the last input transfer is skipped; the
   // word is loaded at the next fall, after the strobe has been run;
   // the rise just before that fall is not counted as a bit.
   // the pin is released at the fall that follows the sixteenth rise,
   // which leaves it driven past that rise
   always_ff @(negedge serialClock or posedge rst) begin
      if (rst) begin
         sdaOe <= 1'b0;
         sdaOut <= 1'b0;
         tailSeen <= 1'b0;
         outCnt <= spp_pkg::OUT_NONE;
         outShift <= 15'h0000;
      end else if (!outPhase) begin
         sdaOe <= 1'b0;
         tailSeen <= 1'b0;
         outCnt <= spp_pkg::OUT_NONE;
      end else if (!tailSeen) begin
         tailSeen <= 1'b1;
      end else if (outCnt == spp_pkg::OUT_NONE) begin
         // latch word is static here: the strobe ended well before
         sdaOe <= 1'b1;
         sdaOut <= dataLatch[0];
         outShift <= dataLatch[15:1];
         outCnt <= spp_pkg::OUT_FIRST;
      end else begin
         sdaOut <= outShift[0];
         outShift <= {1'b0, outShift[14:1]};
         outCnt <= outCnt + 5'h01;
      end
   end

   // ----------------------------------------------------------------
   // pin and toggle synchronisers on the system clock
   // ----------------------------------------------------------------
   // three stages; a level counts once stages two and three agree
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         // all stages start at the idle pin levels (strobe high), so
         // no false strobe edge is seen right after reset
         syncA <= 3'h2;
         syncB <= 3'h2;
         syncC <= 3'h2;
         stable <= 3'h2;
      end else begin
         syncA <= {otpProgrammingMode, programStrobeN, byteTgl};
         syncB <= syncA;
         syncC <= syncB;
         stable <= (stable & ~agree) | (syncC & agree);
      end
   end

   assign agree = ~(syncB ^ syncC);
   assign evt = agree & (syncC ^ stable);
   assign byteEv = evt[0];
   assign strobeFall = evt[1] & ~syncC[1];
   assign strobeRise = evt[1] & syncC[1];
   assign modeOn = stable[2];

   // ----------------------------------------------------------------
   // operation sequencer
   // ----------------------------------------------------------------
   // leaving programming mode drops any half-run operation
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= spp_pkg::ST_CMD;
         op <= spp_pkg::OP_NONE;
      end else if (!modeOn) begin
         state <= spp_pkg::ST_CMD;
      end else begin
         case (state)
            spp_pkg::ST_CMD: begin
               // unknown codes keep waiting for a command
               if (byteEv &&
                   spp_pkg::opOf(byteBuf) != spp_pkg::OP_NONE) begin
                  op <= spp_pkg::opOf(byteBuf);
                  state <= spp_pkg::ST_AL;
               end
            end
            spp_pkg::ST_AL: begin
               if (byteEv) state <= spp_pkg::ST_AH;
            end
            spp_pkg::ST_AH: begin
               // a read takes no data bytes
               if (byteEv) begin
                  state <= (op == spp_pkg::OP_READ) ?
                           spp_pkg::ST_WLO : spp_pkg::ST_DL;
               end
            end
            spp_pkg::ST_DL: begin
               if (byteEv) state <= spp_pkg::ST_DH;
            end
            spp_pkg::ST_DH: begin
               if (byteEv) state <= spp_pkg::ST_WLO;
            end
            spp_pkg::ST_WLO: begin
               if (strobeFall) state <= spp_pkg::ST_WHI;
            end
            spp_pkg::ST_WHI: begin
               // verify waits for a second strobe pulse
               if (strobeRise) begin
                  state <= (op == spp_pkg::OP_VERIFY) ?
                           spp_pkg::ST_W2LO : spp_pkg::ST_CMD;
               end
            end
            spp_pkg::ST_W2LO: begin
               if (strobeFall) state <= spp_pkg::ST_W2HI;
            end
            spp_pkg::ST_W2HI: begin
               if (strobeRise) state <= spp_pkg::ST_CMD;
            end
            default: state <= spp_pkg::ST_CMD;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // address and data capture, low byte first
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         memAddr <= 16'h0000;
         memWdata <= 16'h0000;
      end else if (byteEv && modeOn) begin
         case (state)
            spp_pkg::ST_AL: memAddr[7:0] <= byteBuf;
            spp_pkg::ST_AH: memAddr[15:8] <= byteBuf;
            spp_pkg::ST_DL: memWdata[7:0] <= byteBuf;
            spp_pkg::ST_DH: memWdata[15:8] <= byteBuf;
            default: memWdata <= memWdata;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // memory strobes, one cycle each, on the strobe's falling edge
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         memRead <= 1'b0;
         memWrite <= 1'b0;
      end else begin
         memRead <= modeOn && strobeFall &&
                    ((state == spp_pkg::ST_WLO &&
                      op == spp_pkg::OP_READ) ||
                     state == spp_pkg::ST_W2LO);
         memWrite <= modeOn && strobeFall &&
                     state == spp_pkg::ST_WLO &&
                     op != spp_pkg::OP_READ;
      end
   end

   // ----------------------------------------------------------------
   // internal data latch, loaded one cycle after a read
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdPend <= 1'b0;
         dataLatch <= 16'h0000;
      end else begin
         rdPend <= memRead;
         if (rdPend) dataLatch <= memRdata;
      end
   end

   // ----------------------------------------------------------------
   // checks on the system side
   // ----------------------------------------------------------------
   property p_readFetch;
      @(posedge clock) disable iff (rst)
      modeOn && strobeFall && state == spp_pkg::ST_WLO &&
      op == spp_pkg::OP_READ |=> memRead && !memWrite;
   endproperty
   a_readFetch: assert property (p_readFetch)
      else $error("read strobe did not fetch");

   property p_progWrite;
      @(posedge clock) disable iff (rst)
      modeOn && strobeFall && state == spp_pkg::ST_WLO &&
      op != spp_pkg::OP_READ |=> memWrite && !memRead;
   endproperty
   a_progWrite: assert property (p_progWrite)
      else $error("program strobe did not write");

   property p_verifyRead;
      @(posedge clock) disable iff (rst)
      modeOn && strobeFall && state == spp_pkg::ST_W2LO
      |=> memRead ##1 !memRead ##1 dataLatch == $past(memRdata);
   endproperty
   a_verifyRead: assert property (p_verifyRead)
      else $error("verify read-back not latched");

   property p_ignoreCmd;
      @(posedge clock) disable iff (rst)
      state == spp_pkg::ST_CMD && byteEv &&
      spp_pkg::opOf(byteBuf) == spp_pkg::OP_NONE
      |=> state == spp_pkg::ST_CMD && !memWrite && !memRead;
   endproperty
   a_ignoreCmd: assert property (p_ignoreCmd)
      else $error("unknown command was acted on");

   property p_writeOrigin;
      @(posedge clock) disable iff (rst)
      memWrite |-> $past(state) == spp_pkg::ST_WLO &&
                   state == spp_pkg::ST_WHI;
   endproperty
   a_writeOrigin: assert property (p_writeOrigin)
      else $error("memory written outside a program strobe");

   // ----------------------------------------------------------------
   // checks on the link side
   // ----------------------------------------------------------------
   property p_lsbFirst;
      @(posedge serialClock) disable iff (rst)
      bitCnt == spp_pkg::BIT_LAST && !outPhase
      |=> byteBuf == $past(nextByte) && byteTgl != $past(byteTgl);
   endproperty
   a_lsbFirst: assert property (p_lsbFirst)
      else $error("input byte not handed over lsb first");

   property p_seqEnd;
      @(posedge serialClock) disable iff (rst)
      bitCnt == spp_pkg::BIT_LAST && byteIdx != spp_pkg::IDX_CMD &&
      byteIdx == spp_pkg::lastIdx(cmdOp) |=> byteIdx == spp_pkg::IDX_CMD;
   endproperty
   a_seqEnd: assert property (p_seqEnd)
      else $error("operation did not end after its last transfer");

   property p_oeOn;
      @(negedge serialClock) disable iff (rst)
      outPhase && tailSeen && outCnt == spp_pkg::OUT_NONE
      |=> sdaOe && sdaOut == $past(dataLatch[0]);
   endproperty
   a_oeOn: assert property (p_oeOn)
      else $error("output not enabled at first falling edge");

   property p_shiftOut;
      @(negedge serialClock) disable iff (rst)
      outPhase && outCnt != spp_pkg::OUT_NONE &&
      outCnt != spp_pkg::OUT_BITS |=> sdaOut == $past(outShift[0]);
   endproperty
   a_shiftOut: assert property (p_shiftOut)
      else $error("output bit not advanced on falling edge");

   property p_oeOff;
      @(negedge serialClock) disable iff (rst)
      !outPhase |=> !sdaOe;
   endproperty
   a_oeOff: assert property (p_oeOff)
      else $error("data line still driven after last bit");

endmodule // spp_prog_port

// ===== bench/spp_programmer.sv
// model of the external programmer that drives the serial programming pins
`timescale 1ns/1ps

module spp_programmer (
   // system timebase
   input wire logic clock,
   // programming pins
   output logic serialClock,
   output logic pData,
   input wire logic sdaWire,
   output logic programStrobeN,
   output logic otpProgrammingMode
);
   // ----------------------------------------------------------------
   // link timing
   // ----------------------------------------------------------------
   // half of the 64 ns link period; far below the pin minimum, which
   // squeezes the byte crossing into the system clock harder
   localparam int HALF = 32;

   // pins parked high before the supply is raised
   initial begin
      serialClock = 1'b1;
      pData = 1'b1;
      programStrobeN = 1'b1;
      otpProgrammingMode = 1'b0;
   end

   // ----------------------------------------------------------------
   // pin sequences
   // ----------------------------------------------------------------
   // raise the supply with all pins high, then park the clock low
   task automatic enterMode();
      repeat (4) @(negedge clock);
      otpProgrammingMode = 1'b1;
      repeat (4) @(negedge clock);
      serialClock = 1'b0;
      repeat (4) @(negedge clock);
   endtask

   // one transfer, lsb first; data settles a half period before the rise
   task automatic sendByte(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         pData = b[i];
         #HALF serialClock = 1'b1;
         #HALF serialClock = 1'b0;
      end
      // released line: show the inverse so a stale level is never trusted
      pData = ~pData;
   endtask

   // strobe pulse framed by the wait times on both sides
   task automatic strobe(input int lowCycles);
      repeat (25) @(negedge clock);
      programStrobeN = 1'b0;
      repeat (lowCycles) @(negedge clock);
      programStrobeN = 1'b1;
      repeat (25) @(negedge clock);
   endtask

   // clock out one word: the first pulse only turns the pin round
   task automatic readWord(output logic [15:0] w);
      w = 16'h0000;
      for (int k = 0; k < 17; k++) begin
         #HALF serialClock = 1'b1;
         if (k > 0) begin
            w[k - 1] = sdaWire;
         end
         #HALF serialClock = 1'b0;
      end
   endtask
endmodule // spp_programmer

// ===== bench/spp_prog_port_test.sv
// self-checking bench of the serial programming port
`timescale 1ns/1ps

module spp_prog_port_test;
   // ----------------------------------------------------------------
   // pins, array port and bookkeeping
   // ----------------------------------------------------------------
   logic clock; // system clock
   logic rst; // async reset
   logic serialClock, pData, sdaWire; // link clock, programmer bit, pin
   logic programStrobeN, otpProgrammingMode; // strobe and mode
   logic sdaOut, sdaOe; // device side of the data pin
   logic memRead, memWrite; // array strobes
   logic [15:0] memAddr, memWdata, memRdata; // array port
   logic [15:0] mem [logic [15:0]]; // array contents
   int refMem [int]; // words the bench has programmed
   logic [31:0] expWr [$]; // expected writes, address then data
   logic [15:0] expRd [$]; // expected read addresses
   int failCount, comparisons, oeRises;

   // pin level: device wins while it drives
   assign sdaWire = (sdaOe === 1'b1) ? sdaOut : pData;

   spp_prog_port dut (.clock(clock), .rst(rst), .serialClock(serialClock),
      .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .programStrobeN(programStrobeN),
      .otpProgrammingMode(otpProgrammingMode), .memRead(memRead),
      .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
      .memRdata(memRdata));
   spp_programmer prog (.clock(clock), .serialClock(serialClock),
      .pData(pData), .sdaWire(sdaWire), .programStrobeN(programStrobeN),
      .otpProgrammingMode(otpProgrammingMode));

   // 100 ns system clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // ----------------------------------------------------------------
   // reporting
   // ----------------------------------------------------------------
   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         failCount++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", comparisons, failCount);
      if (failCount == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // monitors and array model
   // ----------------------------------------------------------------
   // array accesses must match what the bench asked for, in order
   always @(negedge clock) begin
      if (memWrite === 1'b1) begin
         check(expWr.size() > 0 && {memAddr, memWdata} === expWr[0],
               "array write");
         if (expWr.size() > 0) void'(expWr.pop_front());
         mem[memAddr] = memWdata;
      end
      if (memRead === 1'b1) begin
         check(expRd.size() > 0 && memAddr === expRd[0],
               "array read");
         if (expRd.size() > 0) void'(expRd.pop_front());
         // blank cells hold arbitrary content
         if (!mem.exists(memAddr)) mem[memAddr] = 16'($urandom);
         memRdata = mem[memAddr];
      end
   end

   // output bit and enable may only move on a falling link edge
   always @(sdaOut) begin
      if (!rst && sdaOe === 1'b1) check(serialClock === 1'b0, "data edge");
   end
   always @(sdaOe) begin
      if (!rst) check(serialClock === 1'b0, "enable edge");
   end
   always @(posedge serialClock) begin
      if (sdaOe === 1'b1) oeRises++;
   end

   // ----------------------------------------------------------------
   // one operation with its expectations
   // ----------------------------------------------------------------
   task automatic doOp(input logic [7:0] cmd, input logic [15:0] a,
                       input logic [15:0] d);
      logic [15:0] w;
      logic [15:0] e;
      logic known;
      known = cmd inside {spp_pkg::CMD_READ, spp_pkg::CMD_PROG,
                          spp_pkg::CMD_VERIFY};
      prog.sendByte(cmd);
      // unknown code: any array access now is caught by the monitor
      if (!known) begin
         repeat (30) @(negedge clock);
         return;
      end
      prog.sendByte(a[7:0]);
      prog.sendByte(a[15:8]);
      if (cmd != spp_pkg::CMD_READ) begin
         prog.sendByte(d[7:0]);
         prog.sendByte(d[15:8]);
         expWr.push_back({a, d});
         refMem[a] = d;
      end else begin
         expRd.push_back(a);
      end
      prog.strobe(cmd == spp_pkg::CMD_READ ? 10 : 2000);
      // an added program pulse must not write again
      if (cmd == spp_pkg::CMD_PROG) prog.strobe(2000);
      if (cmd == spp_pkg::CMD_VERIFY) begin
         expRd.push_back(a);
         prog.strobe(10);
      end
      if (cmd != spp_pkg::CMD_PROG) begin
         e = refMem.exists(a) ? refMem[a][15:0] : mem[a];
         oeRises = 0;
         prog.readWord(w);
         #10;
         check(w === e, "word shifted out");
         check(oeRises == 16 && sdaOe === 1'b0, "drive window");
      end
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] cmds [4];
      rst = 1'b1;
      memRdata = 16'h0000;
      failCount = 0;
      comparisons = 0;
      oeRises = 0;
      void'($urandom(32'h07910FE9));
      repeat (10) @(negedge clock);
      rst = 1'b0;
      check(sdaOe === 1'b0 && memWrite === 1'b0 && memAddr === 16'h0000,
            "reset state");
      prog.enterMode();
      doOp(spp_pkg::CMD_PROG, 16'h00FF, 16'hA55A);
      doOp(spp_pkg::CMD_READ, 16'h00FF, 16'h0000);
      doOp(spp_pkg::CMD_VERIFY, 16'hFF00, 16'h8001);
      doOp(8'h00, 16'h0000, 16'h0000);
      doOp(8'hFF, 16'h0000, 16'h0000);
      doOp(spp_pkg::CMD_READ, 16'h1234, 16'h0000);
      doOp(spp_pkg::CMD_READ, 16'hFF00, 16'h0000);
      // back-to-back random mix, junk codes included
      for (int i = 0; i < 8; i++) begin
         cmds = '{spp_pkg::CMD_READ, spp_pkg::CMD_PROG,
                  spp_pkg::CMD_VERIFY, 8'($urandom)};
         doOp(cmds[$urandom % 4], 16'($urandom), 16'($urandom));
      end
      check(expWr.size() == 0 && expRd.size() == 0, "access left");
      results();
   end

   // watchdog: even with every random operation a program, the sequence needs under four fifths of this span
   initial begin
      #5_000_000;
      failCount++;
      results();
   end
endmodule // spp_prog_port_test
